// ===== core/current_limit_lock_fault.sv
// Fault reaction for the hardware current-limit lock detector.
// Assumes fault_setup_two is the live register value, synchronous to clk_sys,
// and that lock_retry_delay is already given in clock cycles.
`timescale 1ns/1ps

module current_limit_lock_fault
#(
  parameter int DELAY_W = 24
)
(
  input  wire logic               clk_sys,
  input  wire logic               reset_n,
  input  wire logic               current_limit_trip,
  input  wire logic [31:0]        fault_setup_two,
  input  wire logic [DELAY_W-1:0] lock_retry_delay,
  input  wire logic               fault_clear,
  output logic                    fault_indicator_low_ff,
  output logic                    gate_override_ff,
  output logic [1:0]              gate_state_ff,
  output logic                    lock_reported_ff,
  output logic                    lock_latched_ff
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_meta_ff;
  logic rst_n_ff;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  // ****************************************************************
  // Field decode
  // ****************************************************************
  wire [3:0] current_limit_lock_action;
  wire [3:0] current_limit_lock_filter_time;
  wire [2:0] retry_limit_code;
  wire [ilim_lock_pkg::RETRY_CNT_W-1:0] retry_limit;
  wire       mode_latch;
  wire       mode_retry;
  wire       mode_report;
  wire       mode_enabled;

  assign current_limit_lock_action =
    fault_setup_two[ilim_lock_pkg::ACTION_MSB:ilim_lock_pkg::ACTION_LSB];
  assign current_limit_lock_filter_time =
    fault_setup_two[ilim_lock_pkg::FILTER_TIME_MSB:ilim_lock_pkg::FILTER_TIME_LSB];
  assign retry_limit_code =
    fault_setup_two[ilim_lock_pkg::RETRY_LIMIT_MSB:ilim_lock_pkg::RETRY_LIMIT_LSB];
  assign retry_limit = ilim_lock_pkg::retry_limit_decode(retry_limit_code);

  assign mode_latch  = (current_limit_lock_action <= ilim_lock_pkg::ACTION_LATCH_LAST);
  assign mode_retry  = (current_limit_lock_action >= ilim_lock_pkg::ACTION_RETRY_FIRST) &&
                       (current_limit_lock_action <= ilim_lock_pkg::ACTION_RETRY_LAST);
  assign mode_report = (current_limit_lock_action == ilim_lock_pkg::ACTION_REPORT_ONLY);
  // Every code above the report-only code switches the detector off.
  assign mode_enabled = mode_latch || mode_retry || mode_report;

  // ****************************************************************
  // Trip qualification
  // ****************************************************************
  logic qualified;
  logic qualified_d_ff;
  wire  lock_event;

  ilim_trip_filter u_ilim_trip_filter
  (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n_ff),
    .trip         (current_limit_trip),
    .filter_code  (current_limit_lock_filter_time),
    .qualified_ff (qualified)
  );

  // One event per qualified trip; a trip that stays high does not repeat it.
  assign lock_event = qualified && !qualified_d_ff && mode_enabled;

  // ****************************************************************
  // Reaction state machine
  // ****************************************************************
  ilim_lock_pkg::lock_state_type state_ff;
  ilim_lock_pkg::lock_state_type nxt_state;
  logic [DELAY_W-1:0]                   delay_ff;
  logic [DELAY_W-1:0]                   nxt_delay;
  logic [ilim_lock_pkg::RETRY_CNT_W-1:0] retry_cnt_ff;
  logic [ilim_lock_pkg::RETRY_CNT_W-1:0] nxt_retry_cnt;
  logic [1:0]                           hold_gate_ff;
  logic [1:0]                           nxt_hold_gate;

  wire protect_event = lock_event && !mode_report;
  wire limit_hit     = (retry_limit != ilim_lock_pkg::RETRY_NO_LIMIT) &&
                       (retry_cnt_ff >= retry_limit);
  wire delay_done    = (delay_ff == '0);
  wire cnt_full      = (retry_cnt_ff == {ilim_lock_pkg::RETRY_CNT_W{1'b1}});

  always_comb
  begin
    nxt_state     = state_ff;
    nxt_delay     = delay_ff;
    nxt_retry_cnt = retry_cnt_ff;
    nxt_hold_gate = hold_gate_ff;
    unique case (state_ff)
      ilim_lock_pkg::LOCK_IDLE:
      begin
        if (fault_clear)
        begin
          nxt_retry_cnt = '0;
        end
        if (protect_event)
        begin
          nxt_hold_gate = current_limit_lock_action[1:0];
          if (mode_latch || limit_hit)
          begin
            nxt_state = ilim_lock_pkg::LOCK_LATCHED;
          end
          else
          begin
            nxt_state = ilim_lock_pkg::LOCK_RETRY_WAIT;
            nxt_delay = lock_retry_delay;
          end
        end
      end
      ilim_lock_pkg::LOCK_RETRY_WAIT:
      begin
        if (delay_done)
        begin
          nxt_state = ilim_lock_pkg::LOCK_IDLE;
          if (!cnt_full)
          begin
            nxt_retry_cnt = retry_cnt_ff + 1'b1;
          end
        end
        else
        begin
          nxt_delay = delay_ff - 1'b1;
        end
      end
      ilim_lock_pkg::LOCK_LATCHED:
      begin
        // A new event in the clearing cycle keeps the fault latched.
        if (fault_clear && !protect_event)
        begin
          nxt_state     = ilim_lock_pkg::LOCK_IDLE;
          nxt_retry_cnt = '0;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      state_ff       <= ilim_lock_pkg::LOCK_IDLE;
      delay_ff       <= '0;
      retry_cnt_ff   <= '0;
      hold_gate_ff   <= ilim_lock_pkg::GATE_TRISTATE;
      qualified_d_ff <= 1'b0;
    end
    else
    begin
      state_ff       <= nxt_state;
      delay_ff       <= nxt_delay;
      retry_cnt_ff   <= nxt_retry_cnt;
      hold_gate_ff   <= nxt_hold_gate;
      qualified_d_ff <= qualified;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  wire in_fault      = (nxt_state != ilim_lock_pkg::LOCK_IDLE);
  // Report flag is sticky; a new event beats a clear in the same cycle.
  wire nxt_reported  = lock_event || (lock_reported_ff && !fault_clear);

  always_ff @(posedge clk_sys or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      fault_indicator_low_ff <= 1'b1;
      gate_override_ff       <= 1'b0;
      gate_state_ff          <= ilim_lock_pkg::GATE_TRISTATE;
      lock_reported_ff       <= 1'b0;
      lock_latched_ff        <= 1'b0;
    end
    else
    begin
      fault_indicator_low_ff <= !in_fault;
      gate_override_ff       <= in_fault;
      gate_state_ff          <= nxt_hold_gate;
      lock_reported_ff       <= nxt_reported;
      lock_latched_ff        <= (nxt_state == ilim_lock_pkg::LOCK_LATCHED);
    end
  end

endmodule // current_limit_lock_fault

// ===== inc/ilim_lock_pkg.sv
// Constants, field positions and encodings for the current-limit lock fault logic.
// Assumes a 10 MHz system clock; every user includes names with the package scope.
package ilim_lock_pkg;

  // ****************************************************************
  // Clock and filter timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS      = 100;
  localparam int FILTER_STEP_NS     = 1000;
  // A least time, so the division rounds up.
  localparam int FILTER_STEP_CYCLES = (FILTER_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILTER_MAX_US      = 15;
  localparam int FILTER_CNT_W       = 8;

  // ****************************************************************
  // Field positions in fault_setup_two
  // ****************************************************************
  localparam int ACTION_MSB      = 18;
  localparam int ACTION_LSB      = 15;
  localparam int FILTER_TIME_MSB = 14;
  localparam int FILTER_TIME_LSB = 11;
  localparam int RETRY_LIMIT_MSB = 2;
  localparam int RETRY_LIMIT_LSB = 0;
  localparam logic [31:0] FAULT_SETUP_TWO_RESET = 32'h0000_0000;

  // ****************************************************************
  // Action codes
  // ****************************************************************
  localparam logic [3:0] ACTION_LATCH_FIRST = 4'h0;
  localparam logic [3:0] ACTION_LATCH_LAST  = 4'h3;
  localparam logic [3:0] ACTION_RETRY_FIRST = 4'h4;
  localparam logic [3:0] ACTION_RETRY_LAST  = 4'h7;
  localparam logic [3:0] ACTION_REPORT_ONLY = 4'h8;

  // ****************************************************************
  // Gate-driver commands, taken from the low two bits of the action code
  // ****************************************************************
  localparam logic [1:0] GATE_TRISTATE    = 2'h0;
  localparam logic [1:0] GATE_RECIRCULATE = 2'h1;
  localparam logic [1:0] GATE_HIGH_BRAKE  = 2'h2;
  localparam logic [1:0] GATE_LOW_BRAKE   = 2'h3;

  // ****************************************************************
  // Retry limit decode; zero means no limit
  // ****************************************************************
  localparam int RETRY_CNT_W = 5;
  localparam logic [RETRY_CNT_W-1:0] RETRY_NO_LIMIT = 5'h00;

  function automatic logic [RETRY_CNT_W-1:0] retry_limit_decode(input logic [2:0] code);
    logic [RETRY_CNT_W-1:0] lim;
    lim = RETRY_NO_LIMIT;
    unique case (code)
      3'h0: lim = RETRY_NO_LIMIT;
      3'h1: lim = 5'h02;
      3'h2: lim = 5'h03;
      3'h3: lim = 5'h05;
      3'h4: lim = 5'h07;
      3'h5: lim = 5'h0a;
      3'h6: lim = 5'h0f;
      3'h7: lim = 5'h14;
    endcase
    return lim;
  endfunction

  typedef enum logic [1:0] {
    LOCK_IDLE,
    LOCK_RETRY_WAIT,
    LOCK_LATCHED
  } lock_state_type;

endpackage

// ===== core/ilim_trip_filter.sv
// Deglitch filter for the current-limit trip condition.
// Assumes trip is synchronous to clk_sys and rst_n is already synchronised.
`timescale 1ns/1ps

module ilim_trip_filter
(
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       trip,
  input  wire logic [3:0] filter_code,
  output logic            qualified_ff
);

  logic [ilim_lock_pkg::FILTER_CNT_W-1:0] count_ff;
  logic [ilim_lock_pkg::FILTER_CNT_W-1:0] nxt_count;
  logic [ilim_lock_pkg::FILTER_CNT_W-1:0] target;
  logic [ilim_lock_pkg::FILTER_CNT_W-1:0] step;
  logic                                   nxt_qualified;
  logic                                   reached;

  assign step    = ilim_lock_pkg::FILTER_CNT_W'(ilim_lock_pkg::FILTER_STEP_CYCLES);
  // Code n gives n microseconds; code zero passes the trip straight through.
  assign target  = ilim_lock_pkg::FILTER_CNT_W'({4'h0, filter_code} * step);
  assign reached = (count_ff >= target);

  // The count restarts whenever the trip drops, so only a continuous trip qualifies.
  assign nxt_count     = !trip ? '0 : (reached ? count_ff : count_ff + 1'b1);
  assign nxt_qualified = trip && (filter_code == 4'h0 || reached);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_ff     <= '0;
      qualified_ff <= 1'b0;
    end
    else
    begin
      count_ff     <= nxt_count;
      qualified_ff <= nxt_qualified;
    end
  end

endmodule // ilim_trip_filter

// ===== tb/current_limit_lock_fault_chk.sv
// Port assertions for the current-limit lock fault block.
// Bound to the design from the testbench top; sees only the design ports.
`timescale 1ns/1ps
module current_limit_lock_fault_chk
#(
  parameter int DELAY_W = 24
)
(
  input wire logic               clk_sys,
  input wire logic               reset_n,
  input wire logic               current_limit_trip,
  input wire logic [31:0]        fault_setup_two,
  input wire logic [DELAY_W-1:0] lock_retry_delay,
  input wire logic               fault_clear,
  input wire logic               fault_indicator_low_ff,
  input wire logic               gate_override_ff,
  input wire logic [1:0]         gate_state_ff,
  input wire logic               lock_reported_ff,
  input wire logic               lock_latched_ff
);
  wire logic [3:0]    act     = fault_setup_two[18:15];
  wire logic [1:0]    act_low = fault_setup_two[16:15];
  logic [DELAY_W:0]   low_cnt_ff;
  // Times the low phase of the fault pin, so a retry wait is checked to the exact cycle.
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n) low_cnt_ff <= '0;
    else low_cnt_ff <= fault_indicator_low_ff ? '0 : low_cnt_ff + 1'b1;
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  property p_pin_latch; lock_latched_ff |-> !fault_indicator_low_ff; endproperty
  a_pin_latch: assert property (p_pin_latch) else $error("latched fault without pin");
  property p_latch_hold; lock_latched_ff && !fault_clear |=> lock_latched_ff; endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch dropped");
  property p_clear; lock_latched_ff && fault_clear && !current_limit_trip && !$past(current_limit_trip)
    |=> fault_indicator_low_ff && !lock_latched_ff && !lock_reported_ff; endproperty
  a_clear: assert property (p_clear) else $error("clear ignored");
  property p_ov_pin; gate_override_ff == !fault_indicator_low_ff; endproperty
  a_ov_pin: assert property (p_ov_pin) else $error("override and pin disagree");
  property p_gate; $rose(gate_override_ff) |-> gate_state_ff == $past(act_low); endproperty
  a_gate: assert property (p_gate) else $error("wrong gate state");
  property p_ov_codes; $rose(gate_override_ff) |-> $past(act) <= 4'h7; endproperty
  a_ov_codes: assert property (p_ov_codes) else $error("override in report or off code");
  property p_latch_codes; $rose(gate_override_ff) && $past(act) <= 4'h3 |-> lock_latched_ff; endproperty
  a_latch_codes: assert property (p_latch_codes) else $error("latch codes did not latch");
  property p_report_codes; $rose(lock_reported_ff) |-> $past(act) <= 4'h8; endproperty
  a_report_codes: assert property (p_report_codes) else $error("report while disabled");
  property p_retry_time; $rose(fault_indicator_low_ff) && !$past(lock_latched_ff)
    |-> low_cnt_ff == lock_retry_delay + 1; endproperty
  a_retry_time: assert property (p_retry_time) else $error("retry wait length wrong");
  c_latched: cover property (lock_latched_ff);
  c_retry: cover property ($rose(fault_indicator_low_ff) && !$past(lock_latched_ff));
  c_report: cover property (lock_reported_ff && !gate_override_ff);
endmodule // current_limit_lock_fault_chk

// ===== tb/power_stage_model.sv
// Power stage side: raises the current-limit trip in bursts of whole cycles.
// Drives on the falling clock edge; the bench calls burst by hierarchical name.
`timescale 1ns/1ps
module power_stage_model
(
  input  wire logic clk_sys,
  output logic      trip
);
  initial trip = 1'b0;
  // Whole-cycle bursts keep the deglitch boundary exact.
  task automatic burst(input int cycles);
    @(negedge clk_sys);
    trip = 1'b1;
    repeat (cycles) @(negedge clk_sys);
    trip = 1'b0;
  endtask
endmodule // power_stage_model

// ===== tb/current_limit_lock_fault_test.sv
// Self-checking bench for the current-limit lock fault block.
// Trip comes from the power stage model; the checker is bound at the foot.
`timescale 1ns/1ps
module current_limit_lock_fault_test;
  logic        clk_sys          = 1'b0;
  logic        reset_n          = 1'b0;
  logic [31:0] fault_setup_two  = 32'h0;
  logic [23:0] lock_retry_delay = 24'h5;
  logic        fault_clear      = 1'b0;
  logic        trip, pin, ov, rep, lat;
  logic [1:0]  gate;
  logic [1:0]  m_gate = 2'h0;
  int          m_retries = 0;
  int          fail_count = 0;
  int          samples_checked = 0;
  int          n, rnd, lc, ac;
  int          lim_tab[8] = '{0, 2, 3, 5, 7, 10, 15, 20};
  wire logic [5:0] seen_v = {pin, ov, gate, rep, lat};
  always #50 clk_sys = ~clk_sys;
  power_stage_model u_power_stage_model (.clk_sys(clk_sys), .trip(trip));
  current_limit_lock_fault u_current_limit_lock_fault (.clk_sys(clk_sys), .reset_n(reset_n),
    .current_limit_trip(trip), .fault_setup_two(fault_setup_two), .lock_retry_delay(lock_retry_delay),
    .fault_clear(fault_clear), .fault_indicator_low_ff(pin), .gate_override_ff(ov),
    .gate_state_ff(gate), .lock_reported_ff(rep), .lock_latched_ff(lat));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [5:0] seen, input logic [5:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: outputs %b expected %b", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Unused register bits get random values; the block must ignore them.
  task automatic setup(input logic [3:0] a, input logic [3:0] f, input logic [2:0] l);
    fault_setup_two = $urandom;
    fault_setup_two[18:15] = a;
    fault_setup_two[14:11] = f;
    fault_setup_two[2:0] = l;
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic hit(input int a, input int lim, input int len);
    bit prot;
    prot = a <= 7;
    u_power_stage_model.burst(len);
    repeat (3) @(negedge clk_sys);
    if (prot) m_gate = 2'(a);
    check(seen_v, {~prot, prot, m_gate, a <= 8, a <= 3 || (prot && lim != 0 && m_retries >= lim)});
  endtask
  task automatic wait_retry();
    repeat (lock_retry_delay + 3) @(negedge clk_sys);
    m_retries++;
    check(seen_v, {2'b10, m_gate, 2'b10});
  endtask
  task automatic clear();
    fault_clear = 1'b1;
    @(negedge clk_sys);
    fault_clear = 1'b0;
    @(negedge clk_sys);
    m_retries = 0;
    check(seen_v, {2'b10, m_gate, 2'b00});
  endtask
  initial
  begin
    rnd = $urandom(32'h1930e72a);
    repeat (5) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    check(seen_v, 6'h20);
    lock_retry_delay = 24'(2 + $urandom % 8);
    for (int a = 0; a < 16; a++)
    begin
      setup(4'(a), 4'h0, 3'h0);
      hit(a, 0, 1);
      if (a >= 4 && a <= 7) wait_retry();
      clear();
    end
    setup(4'h5, 4'h0, 3'h1);
    for (int i = 0; i < 3; i++)
    begin
      hit(5, lim_tab[1], 1);
      if (i < 2) wait_retry();
    end
    clear();
    // Random limit code and retry code, so any nonzero limit code, 1 to 7, can be drawn.
    lc = 1 + $urandom % 7;
    ac = 4 + $urandom % 4;
    setup(4'(ac), 4'h0, 3'(lc));
    for (int i = 0; i <= lim_tab[lc]; i++)
    begin
      hit(ac, lim_tab[lc], 1);
      if (i < lim_tab[lc]) wait_retry();
    end
    clear();
    n = 1 + $urandom % 15;
    setup(4'h8, 4'(n), 3'h0);
    u_power_stage_model.burst(n * 10);
    repeat (3) @(negedge clk_sys);
    check(seen_v, {2'b10, m_gate, 2'b00});
    hit(8, 0, n * 10 + 1);
    clear();
    // Reset in the middle of a latched fault; every output must return to idle.
    setup(4'h3, 4'h0, 3'h0);
    hit(3, 0, 1);
    reset_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    reset_n = 1'b1;
    m_gate = 2'h0;
    m_retries = 0;
    repeat (3) @(negedge clk_sys);
    check(seen_v, 6'h20);
    results();
  end
  // Every wait above is a fixed count; this bounds the whole run in case one hangs.
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    results();
  end
endmodule // current_limit_lock_fault_test
bind current_limit_lock_fault current_limit_lock_fault_chk #(.DELAY_W(DELAY_W)) u_current_limit_lock_fault_chk (
  .clk_sys(clk_sys), .reset_n(reset_n), .current_limit_trip(current_limit_trip),
  .fault_setup_two(fault_setup_two), .lock_retry_delay(lock_retry_delay), .fault_clear(fault_clear),
  .fault_indicator_low_ff(fault_indicator_low_ff), .gate_override_ff(gate_override_ff),
  .gate_state_ff(gate_state_ff), .lock_reported_ff(lock_reported_ff), .lock_latched_ff(lock_latched_ff));
